// ---- src/fsr_pkg.sv ----
// Shared constants and types for the flash status register block
package fsr_pkg;
	// Command opcodes
	localparam logic [7:0] OPC_RD_STATUS_ONE = 8'h05;
	localparam logic [7:0] OPC_RD_STATUS_TWO = 8'h07;
	localparam logic [7:0] OPC_REG_WRITE = 8'h01;
	localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OPC_CLEAR_STATUS_A = 8'h30;
	localparam logic [7:0] OPC_CLEAR_STATUS_B = 8'h82;
	localparam logic [7:0] OPC_ANY_REG_READ = 8'h65;
	localparam logic [7:0] OPC_ANY_REG_WRITE = 8'h71;
	localparam logic [7:0] OPC_ERASE_SUSPEND = 8'h75;
	localparam logic [7:0] OPC_PROGRAM_SUSPEND = 8'h85;
	localparam logic [7:0] OPC_RESUME = 8'h7a;
	localparam logic [7:0] OPC_SOFT_RESET = 8'hf0;
	localparam logic [7:0] OPC_PROGRAM = 8'h02;
	localparam logic [7:0] OPC_SECTOR_ERASE = 8'hd8;
	localparam logic [7:0] OPC_WHOLE_ERASE = 8'h60;
	localparam logic [7:0] OPC_ERASE_STATUS = 8'hd0;
	// Field positions, first status register
	localparam int BIT_LOCK = 7;
	localparam int BIT_PERR = 6;
	localparam int BIT_EERR = 5;
	localparam int BP_HI = 4;
	localparam int BP_LO = 2;
	localparam int BIT_WEL = 1;
	localparam int BIT_BUSY = 0;
	// Field positions, second status register
	localparam int BIT_ERASE_RESULT_FLAG = 2;
	localparam int BIT_ES = 1;
	localparam int BIT_PS = 0;
	// Register addresses for the any-register commands
	localparam logic [23:0] ADDR_STATUS_ONE_NV = 24'h000000;
	localparam logic [23:0] ADDR_STATUS_ONE = 24'h800000;
	localparam logic [23:0] ADDR_STATUS_TWO = 24'h800001;
	// Byte positions within a frame
	localparam logic [2:0] IDX_REG_DATA = 3'h1;
	localparam logic [2:0] IDX_ADDR_DONE = 3'h4;
	localparam logic [2:0] IDX_ANY_DATA = 3'h5;
	localparam logic [2:0] IDX_MAX = 3'h7;
	// Reset values
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [2:0] BP_ZERO = 3'h0;
	localparam logic [23:0] ADDR_ZERO = 24'h000000;
	// Kind of array operation started
	typedef enum logic [1:0] {
		KIND_PROGRAM = 2'b00,
		KIND_SECTOR_ERASE = 2'b01,
		KIND_WHOLE_ERASE = 2'b10
	} fsr_kind_t;
	// Array operation state
	typedef enum logic [2:0] {
		OP_IDLE = 3'b000,
		OP_PROGRAM = 3'b001,
		OP_ERASE = 3'b010,
		OP_WHOLE = 3'b011,
		OP_PROG_SUSP = 3'b100,
		OP_ERASE_SUSP = 3'b101,
		OP_FAULT = 3'b110
	} fsr_op_t;
endpackage

// ---- src/fsr_link_if.sv ----
// Byte-level link between the serial front end and the register core
`timescale 1ns/1ns
`default_nettype none
interface fsr_link_if;
	logic byte_valid;
	logic [7:0] rx_byte;
	logic frame_start;
	logic frame_end;
	logic wp_level;
	logic [7:0] tx_byte;
	modport link (output byte_valid, rx_byte, frame_start, frame_end, wp_level, input tx_byte);
	modport core (input byte_valid, rx_byte, frame_start, frame_end, wp_level, output tx_byte);
endinterface
`default_nettype wire

// ---- src/fsr_spi_link.sv ----
// Serial front end: pin synchronisers, bit shifting, byte framing
`timescale 1ns/1ns
`default_nettype none
module fsr_spi_link
	import fsr_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic sck_in,
	input wire logic cs_n_in,
	input wire logic si_in,
	input wire logic wp_n_in,
	output logic so_out,
	output logic so_oe_out,
	fsr_link_if.link lk
);
	logic [3:0] s1_reg, s2_reg, s1_next, s2_next;
	logic sck_d_reg, cs_d_reg, sck_d_next, cs_d_next;
	logic [2:0] cnt_reg, cnt_next;
	logic [7:0] rx_reg, rx_next, tx_reg, tx_next, byte_reg, byte_next;
	logic bv_reg, bv_next, st_reg, st_next, en_reg, en_next, oe_reg, oe_next;
	logic sck_s, cs_s, rise, fall;

	// Second stage of each synchroniser
	assign sck_s = s2_reg[0];
	assign cs_s = s2_reg[1];
	assign rise = sck_s & ~sck_d_reg & ~cs_s;
	assign fall = ~sck_s & sck_d_reg & ~cs_s;

	// Next-state for shifting and framing
	always_comb
	begin
		s1_next = {wp_n_in, si_in, cs_n_in, sck_in};
		s2_next = s1_reg;
		sck_d_next = sck_s;
		cs_d_next = cs_s;
		cnt_next = cnt_reg;
		rx_next = rx_reg;
		tx_next = tx_reg;
		byte_next = byte_reg;
		bv_next = 1'b0;
		st_next = cs_d_reg & ~cs_s;
		en_next = ~cs_d_reg & cs_s;
		oe_next = ~cs_s;
		if (cs_s)
			cnt_next = 3'h0;
		if (rise)
		begin
			rx_next = {rx_reg[6:0], s2_reg[2]};
			cnt_next = cnt_reg + 3'h1;
			if (cnt_reg == IDX_MAX)
			begin
				bv_next = 1'b1;
				byte_next = {rx_reg[6:0], s2_reg[2]};
			end
		end
		if (fall)
			tx_next = (cnt_reg == 3'h0) ? lk.tx_byte : {tx_reg[6:0], 1'b0};
	end

	// Registers
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			s1_reg <= 4'hf;
			s2_reg <= 4'hf;
			sck_d_reg <= 1'b1;
			cs_d_reg <= 1'b1;
			cnt_reg <= 3'h0;
			rx_reg <= BYTE_ZERO;
			tx_reg <= BYTE_ZERO;
			byte_reg <= BYTE_ZERO;
			bv_reg <= 1'b0;
			st_reg <= 1'b0;
			en_reg <= 1'b0;
			oe_reg <= 1'b0;
		end
		else
		begin
			s1_reg <= s1_next;
			s2_reg <= s2_next;
			sck_d_reg <= sck_d_next;
			cs_d_reg <= cs_d_next;
			cnt_reg <= cnt_next;
			rx_reg <= rx_next;
			tx_reg <= tx_next;
			byte_reg <= byte_next;
			bv_reg <= bv_next;
			st_reg <= st_next;
			en_reg <= en_next;
			oe_reg <= oe_next;
		end
	end

	// Outputs toward pins and core
	assign so_out = tx_reg[7];
	assign so_oe_out = oe_reg;
	assign lk.byte_valid = bv_reg;
	assign lk.rx_byte = byte_reg;
	assign lk.frame_start = st_reg;
	assign lk.frame_end = en_reg;
	assign lk.wp_level = s2_reg[3];
endmodule // fsr_spi_link
`default_nettype wire

// ---- src/fsr_status_core.sv ----
// Status register core: command decode, flags, protection, suspend
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Lock copy bit tracks nonvolatile lock, read only
// - Program failure or protected program sets program error
// - Only clear-status and software reset clear error flags
// - Erase failure or protected sector sets erase error
// - Whole erase hitting protected sector: no error, unless suspended and resumed (it then runs as OP_ERASE and sets erase error)
// - Nonvolatile mode: write programs and copies protection
// - Volatile mode: write updates volatile protection only
// - Any protection bit blocks; whole erase needs zero
// - Writes, programs, erases need write-enable latch
// - Enable sets latch, disable clears it
// - Latch clears after successful operation
// - Latch zero after any reset
// - While busy only listed commands are accepted
// - Suspends accepted only during matching operation
// - Error keeps busy until clear-status or software reset
// - First status readable by command and any-register
// - Second status read only, upper bits zero
// - Erase-status command loads erase result bit
// - Erase result invalid while suspended
// - Erase-suspended flag follows erase suspend mode
// - Program-suspended flag follows program suspend mode
// - Lock with write-protect low blocks status writes
module fsr_status_core
	import fsr_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic sck_in,
	input wire logic cs_n_in,
	input wire logic si_in,
	input wire logic wp_n_in,
	output logic so_out,
	output logic so_oe_out,
	input wire logic status_write_lock_nv_in,
	input wire logic [2:0] protect_level_nv_in,
	input wire logic protect_volatility_select_in,
	input wire logic target_protected_in,
	input wire logic sector_erase_complete_in,
	input wire logic array_done_in,
	input wire logic array_fail_in,
	input wire logic array_protect_hit_in,
	output logic array_start_out,
	output logic [1:0] array_kind_out,
	output logic [23:0] array_addr_out,
	output logic array_suspend_out,
	output logic array_resume_out,
	output logic nv_protect_write_out,
	output logic [2:0] nv_protect_data_out,
	output logic [2:0] protect_level_out,
	output logic soft_reset_out
);
	fsr_link_if lk ();

	fsr_spi_link u_link (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.sck_in(sck_in),
		.cs_n_in(cs_n_in),
		.si_in(si_in),
		.wp_n_in(wp_n_in),
		.so_out(so_out),
		.so_oe_out(so_oe_out),
		.lk(lk)
	);

	fsr_op_t op_reg, op_next;
	logic [7:0] opc_reg, opc_next, dat_reg, dat_next, tx_reg, tx_next;
	logic [2:0] idx_reg, idx_next, bpv_reg, bpv_next;
	logic [23:0] addr_reg, addr_next;
	logic wel_reg, wel_next, perr_reg, perr_next, eerr_reg, eerr_next;
	logic lock_reg, lock_next, erase_result_flag_reg, erase_result_flag_next, load_reg;
	logic st_reg, st_next, sus_reg, sus_next, res_reg, res_next;
	logic nvw_reg, nvw_next, rst_reg, rst_next;
	logic [1:0] kind_reg, kind_next;
	logic [23:0] aad_reg, aad_next;
	logic [2:0] nvd_reg, nvd_next;
	logic [7:0] sr1, sr2, sel;
	logic [2:0] bp_eff;
	logic busy, susp, clr, wr_lock, wr_ok;
	logic [7:0] wr_val;

	// Effective protection level
	assign bp_eff = protect_volatility_select_in ? bpv_reg : protect_level_nv_in;
	assign busy = (op_reg == OP_PROGRAM) | (op_reg == OP_ERASE)
		| (op_reg == OP_WHOLE) | (op_reg == OP_FAULT);
	assign susp = (op_reg == OP_PROG_SUSP) | (op_reg == OP_ERASE_SUSP);
	assign wr_lock = lock_reg & ~lk.wp_level;

	// First and second status register images
	always_comb
	begin
		sr1 = BYTE_ZERO;
		sr1[BIT_LOCK] = lock_reg;
		sr1[BIT_PERR] = perr_reg;
		sr1[BIT_EERR] = eerr_reg;
		sr1[BP_HI:BP_LO] = bp_eff;
		sr1[BIT_WEL] = wel_reg;
		sr1[BIT_BUSY] = busy;
		sr2 = BYTE_ZERO;
		sr2[BIT_ERASE_RESULT_FLAG] = erase_result_flag_reg & ~susp;
		sr2[BIT_ES] = (op_reg == OP_ERASE_SUSP);
		sr2[BIT_PS] = (op_reg == OP_PROG_SUSP);
	end

	// Register selected by any-register address
	always_comb
	begin
		sel = BYTE_ZERO;
		if (addr_reg == ADDR_STATUS_ONE)
			sel = sr1;
		else if (addr_reg == ADDR_STATUS_TWO)
			sel = sr2;
		else if (addr_reg == ADDR_STATUS_ONE_NV)
			sel = {status_write_lock_nv_in, 2'b00, protect_level_nv_in, 2'b00};
	end

	// Frame decode and status update
	always_comb
	begin
		op_next = op_reg;
		opc_next = opc_reg;
		idx_next = idx_reg;
		addr_next = addr_reg;
		dat_next = dat_reg;
		wel_next = wel_reg;
		perr_next = perr_reg;
		eerr_next = eerr_reg;
		bpv_next = bpv_reg;
		lock_next = status_write_lock_nv_in;
		erase_result_flag_next = erase_result_flag_reg;
		st_next = 1'b0;
		sus_next = 1'b0;
		res_next = 1'b0;
		nvw_next = 1'b0;
		rst_next = 1'b0;
		kind_next = kind_reg;
		aad_next = aad_reg;
		nvd_next = nvd_reg;
		clr = 1'b0;
		wr_ok = 1'b0;
		wr_val = BYTE_ZERO;
		tx_next = BYTE_ZERO;
		// Volatile bits mirror nonvolatile ones in that mode
		if (!protect_volatility_select_in || load_reg)
			bpv_next = protect_level_nv_in;
		// Byte capture
		if (lk.frame_start)
			idx_next = 3'h0;
		if (lk.byte_valid)
		begin
			if (idx_reg == 3'h0)
				opc_next = lk.rx_byte;
			else if (idx_reg < IDX_ADDR_DONE)
				addr_next = {addr_reg[15:0], lk.rx_byte};
			if ((idx_reg == IDX_REG_DATA && opc_reg == OPC_REG_WRITE)
				|| (idx_reg == IDX_ADDR_DONE && opc_reg == OPC_ANY_REG_WRITE))
				dat_next = lk.rx_byte;
			if (idx_reg != IDX_MAX)
				idx_next = idx_reg + 3'h1;
		end
		// Read responses
		unique case (opc_reg)
			OPC_RD_STATUS_ONE: tx_next = sr1;
			OPC_RD_STATUS_TWO: tx_next = sr2;
			OPC_ANY_REG_READ: tx_next = (idx_reg >= IDX_ADDR_DONE) ? sel : BYTE_ZERO;
			default: tx_next = BYTE_ZERO;
		endcase
		// Command execution at frame end
		if (lk.frame_end && idx_reg != 3'h0)
		begin
			unique case (opc_reg)
				OPC_WRITE_ENABLE: if (!busy) wel_next = 1'b1;
				OPC_WRITE_DISABLE: if (!busy) wel_next = 1'b0;
				OPC_CLEAR_STATUS_A, OPC_CLEAR_STATUS_B: clr = 1'b1;
				OPC_SOFT_RESET:
				begin
					wel_next = 1'b0;
					perr_next = 1'b0;
					eerr_next = 1'b0;
					op_next = OP_IDLE;
					bpv_next = protect_level_nv_in;
					rst_next = 1'b1;
				end
				OPC_REG_WRITE:
				begin
					wr_ok = idx_reg > IDX_REG_DATA;
					wr_val = dat_reg;
				end
				OPC_ANY_REG_WRITE:
				begin
					wr_ok = idx_reg > IDX_ADDR_DONE
						&& (addr_reg == ADDR_STATUS_ONE || addr_reg == ADDR_STATUS_ONE_NV);
					wr_val = dat_reg;
				end
				OPC_ERASE_SUSPEND:
					if (op_reg == OP_ERASE || op_reg == OP_WHOLE)
					begin
						op_next = OP_ERASE_SUSP;
						sus_next = 1'b1;
					end
				OPC_PROGRAM_SUSPEND:
					if (op_reg == OP_PROGRAM)
					begin
						op_next = OP_PROG_SUSP;
						sus_next = 1'b1;
					end
				OPC_RESUME:
					if (susp)
					begin
						op_next = (op_reg == OP_PROG_SUSP) ? OP_PROGRAM : OP_ERASE;
						res_next = 1'b1;
					end
				OPC_ERASE_STATUS:
					if (!busy && idx_reg >= IDX_ADDR_DONE)
						erase_result_flag_next = sector_erase_complete_in;
				OPC_PROGRAM, OPC_SECTOR_ERASE:
					if (!busy && !susp && wel_reg && idx_reg >= IDX_ADDR_DONE)
					begin
						if (target_protected_in)
						begin
							// Protected target: flag error and hold busy
							if (opc_reg == OPC_PROGRAM)
								perr_next = 1'b1;
							else
								eerr_next = 1'b1;
							op_next = OP_FAULT;
						end
						else
						begin
							st_next = 1'b1;
							aad_next = addr_reg;
							kind_next = (opc_reg == OPC_PROGRAM) ? KIND_PROGRAM : KIND_SECTOR_ERASE;
							op_next = (opc_reg == OPC_PROGRAM) ? OP_PROGRAM : OP_ERASE;
						end
					end
				OPC_WHOLE_ERASE:
					if (!busy && !susp && wel_reg && bp_eff == BP_ZERO)
					begin
						st_next = 1'b1;
						aad_next = ADDR_ZERO;
						kind_next = KIND_WHOLE_ERASE;
						op_next = OP_WHOLE;
					end
				default: ;
			endcase
		end
		// Register write of the first status register
		if (wr_ok && wel_reg && !busy && !wr_lock)
		begin
			if (protect_volatility_select_in)
				bpv_next = wr_val[BP_HI:BP_LO];
			else
			begin
				nvw_next = 1'b1;
				nvd_next = wr_val[BP_HI:BP_LO];
				bpv_next = wr_val[BP_HI:BP_LO];
			end
			wel_next = 1'b0;
		end
		// Clear status: errors drop, fault returns to standby
		if (clr)
		begin
			perr_next = 1'b0;
			eerr_next = 1'b0;
			if (op_reg == OP_FAULT)
				op_next = OP_IDLE;
		end
		// Array completion; a set beats a same-cycle clear
		if (array_done_in && (op_reg == OP_PROGRAM || op_reg == OP_ERASE || op_reg == OP_WHOLE))
		begin
			if (array_fail_in && !(op_reg == OP_WHOLE && array_protect_hit_in))
			begin
				if (op_reg == OP_PROGRAM)
					perr_next = 1'b1;
				else
					eerr_next = 1'b1;
				op_next = OP_FAULT;
			end
			else
			begin
				op_next = OP_IDLE;
				wel_next = 1'b0;
			end
		end
	end

	// State registers
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			op_reg <= OP_IDLE;
			opc_reg <= BYTE_ZERO;
			idx_reg <= 3'h0;
			addr_reg <= ADDR_ZERO;
			dat_reg <= BYTE_ZERO;
			wel_reg <= 1'b0;
			perr_reg <= 1'b0;
			eerr_reg <= 1'b0;
			bpv_reg <= BP_ZERO;
			lock_reg <= 1'b0;
			erase_result_flag_reg <= 1'b0;
			load_reg <= 1'b1;
			tx_reg <= BYTE_ZERO;
			st_reg <= 1'b0;
			sus_reg <= 1'b0;
			res_reg <= 1'b0;
			nvw_reg <= 1'b0;
			rst_reg <= 1'b0;
			kind_reg <= KIND_PROGRAM;
			aad_reg <= ADDR_ZERO;
			nvd_reg <= BP_ZERO;
		end
		else
		begin
			op_reg <= op_next;
			opc_reg <= opc_next;
			idx_reg <= idx_next;
			addr_reg <= addr_next;
			dat_reg <= dat_next;
			wel_reg <= wel_next;
			perr_reg <= perr_next;
			eerr_reg <= eerr_next;
			bpv_reg <= bpv_next;
			lock_reg <= lock_next;
			erase_result_flag_reg <= erase_result_flag_next;
			load_reg <= 1'b0;
			tx_reg <= tx_next;
			st_reg <= st_next;
			sus_reg <= sus_next;
			res_reg <= res_next;
			nvw_reg <= nvw_next;
			rst_reg <= rst_next;
			kind_reg <= kind_next;
			aad_reg <= aad_next;
			nvd_reg <= nvd_next;
		end
	end

	// Outputs
	assign lk.tx_byte = tx_reg;
	assign array_start_out = st_reg;
	assign array_kind_out = kind_reg;
	assign array_addr_out = aad_reg;
	assign array_suspend_out = sus_reg;
	assign array_resume_out = res_reg;
	assign nv_protect_write_out = nvw_reg;
	assign nv_protect_data_out = nvd_reg;
	assign protect_level_out = bp_eff;
	assign soft_reset_out = rst_reg;
endmodule // fsr_status_core
`default_nettype wire

// ---- tb/fsr_host_model.sv ----
// Host-side serial controller model that issues command frames
`timescale 1ns/1ns
`default_nettype none
module fsr_host_model (
	input wire logic clk_in,
	input wire logic so_in,
	output logic sck_out,
	output logic cs_n_out,
	output logic si_out
);
	logic [7:0] got;
	event got_ev;
	// Idle pins: deselected, clock low
	initial
	begin
		sck_out = 1'b0;
		cs_n_out = 1'b1;
		si_out = 1'b0;
		got = 8'h00;
	end
	// Half period of the serial clock, 80 ns
	task automatic half();
		repeat (8) @(negedge clk_in);
	endtask
	// One frame of n bytes MSB first; last byte shifted in is reported
	task automatic xfer(input logic [39:0] d, input int n, input bit chk);
		logic [39:0] sh;
		sh = d;
		cs_n_out = 1'b0;
		for (int i = 0; i < n * 8; i++)
		begin
			si_out = sh[39];
			sh = {sh[38:0], 1'b0};
			half();
			sck_out = 1'b1;
			got = {got[6:0], so_in};
			half();
			sck_out = 1'b0;
		end
		half();
		cs_n_out = 1'b1;
		si_out = ~si_out; // Released line shows no stale value
		repeat (12) @(negedge clk_in);
		if (chk)
			->got_ev;
	endtask
endmodule // fsr_host_model
`default_nettype wire

// ---- tb/fsr_status_asserts.sv ----
// Port-level assertions for the status register core
`timescale 1ns/1ns
`default_nettype none
module fsr_status_asserts
	import fsr_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic cs_n_in,
	input wire logic so_oe_out,
	input wire logic [2:0] protect_level_nv_in,
	input wire logic protect_volatility_select_in,
	input wire logic array_done_in,
	input wire logic array_start_out,
	input wire logic [1:0] array_kind_out,
	input wire logic array_suspend_out,
	input wire logic array_resume_out,
	input wire logic nv_protect_write_out,
	input wire logic [2:0] protect_level_out
);
	logic [1:0] trk_reg;
	logic [1:0] trk_next;
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!reset_n_in);
	// Bit 1: operation running, bit 0: suspended
	always_comb
	begin
		trk_next[1] = (trk_reg[1] | array_start_out) & ~array_done_in;
		trk_next[0] = (trk_reg[0] | array_suspend_out) & ~array_resume_out;
	end
	always_ff @(posedge clk_in or negedge reset_n_in)
		if (!reset_n_in)
			trk_reg <= 2'b00;
		else
			trk_reg <= trk_next;
	a_nv_write_mode: assert property (nv_protect_write_out |-> !protect_volatility_select_in)
		else $error("nonvolatile protection written in volatile mode");
	a_prot_nv_mode: assert property ($past(reset_n_in, 2) && !protect_volatility_select_in
		|-> protect_level_out == protect_level_nv_in)
		else $error("protection not taken from nonvolatile bits");
	a_whole_needs_zero: assert property (array_start_out && array_kind_out == KIND_WHOLE_ERASE
		|-> protect_level_out == BP_ZERO)
		else $error("whole erase started while protected");
	a_suspend_running: assert property (array_suspend_out |-> trk_reg == 2'b10)
		else $error("suspend without a running operation");
	a_resume_suspended: assert property (array_resume_out |-> trk_reg[0])
		else $error("resume without a suspended operation");
	a_start_idle: assert property (array_start_out |-> !trk_reg[1])
		else $error("operation started while busy");
	a_start_cs_high: assert property (array_start_out |-> cs_n_in && $past(cs_n_in, 2))
		else $error("operation started inside a frame");
	a_oe_idle: assert property (cs_n_in [*5] |-> !so_oe_out)
		else $error("output driven while deselected");
	a_oe_frame: assert property (!cs_n_in [*5] |-> so_oe_out)
		else $error("output not driven while selected");
endmodule // fsr_status_asserts
bind fsr_status_core fsr_status_asserts i_chk (.clk_in(clk_in), .reset_n_in(reset_n_in),
	.cs_n_in(cs_n_in), .so_oe_out(so_oe_out), .protect_level_nv_in(protect_level_nv_in),
	.protect_volatility_select_in(protect_volatility_select_in), .array_done_in(array_done_in),
	.array_start_out(array_start_out), .array_kind_out(array_kind_out),
	.array_suspend_out(array_suspend_out), .array_resume_out(array_resume_out),
	.nv_protect_write_out(nv_protect_write_out), .protect_level_out(protect_level_out));
`default_nettype wire

// ---- tb/flash_status_registers_test.sv ----
// Self-checking bench for the flash status register core
`timescale 1ns/1ns
`default_nettype none
module flash_status_registers_test
	import fsr_pkg::*;
;
	logic clk_in, reset_n_in, sck, cs_n, si, so, wp_n, lock_nv, vol_sel, tgt, sec_done;
	logic done, fail, hit, start, nv_wr, srst;
	logic [1:0] kind;
	logic [23:0] addr;
	logic [25:0] e_op;
	logic [2:0] prot_nv, nv_data, prot;
	logic [7:0] exp_q[$];
	logic [25:0] kind_q[$];
	logic [31:0] r;
	int n_fail, comparisons, seed, n_srst;
	fsr_status_core i_dut (
		.clk_in(clk_in), .reset_n_in(reset_n_in), .sck_in(sck), .cs_n_in(cs_n), .si_in(si),
		.wp_n_in(wp_n), .so_out(so), .so_oe_out(), .status_write_lock_nv_in(lock_nv),
		.protect_level_nv_in(prot_nv), .protect_volatility_select_in(vol_sel),
		.target_protected_in(tgt), .sector_erase_complete_in(sec_done), .array_done_in(done),
		.array_fail_in(fail), .array_protect_hit_in(hit), .array_start_out(start),
		.array_kind_out(kind), .array_addr_out(addr), .array_suspend_out(), .array_resume_out(),
		.nv_protect_write_out(nv_wr), .nv_protect_data_out(nv_data), .protect_level_out(prot),
		.soft_reset_out(srst)
	);
	fsr_host_model i_host (.clk_in(clk_in), .so_in(so), .sck_out(sck), .cs_n_out(cs_n), .si_out(si));
	// 100 MHz clock
	initial
	begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Frame of op plus address or data, n bytes in all
	task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int n);
		i_host.xfer({op, a, 8'h00}, n, 1'b0);
	endtask
	// Status read with the expected byte noted first
	task automatic rd(input logic [7:0] op, input logic [23:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		i_host.xfer({op, a, 8'h00}, (op == OPC_ANY_REG_READ) ? 5 : 2, 1'b1);
	endtask
	// Array reports the end of an operation
	task automatic finish_op(input logic f, input logic h);
		fail = f;
		hit = h;
		done = 1'b1;
		@(negedge clk_in);
		done = 1'b0;
		fail = 1'b0;
		hit = 1'b0;
		repeat (4) @(negedge clk_in);
	endtask
	// Read-back comparison against the oldest note
	initial
		forever
		begin
			@(i_host.got_ev);
			chk("status byte", exp_q.pop_front(), i_host.got);
		end
	// Every started operation must have been announced, kind and upper two address bytes
	always @(negedge clk_in)
		if (start === 1'b1)
		begin
			e_op = (kind_q.size() > 0) ? kind_q.pop_front() : 26'h3ffffff;
			chk("array kind", {6'h0, e_op[25:24]}, {6'h0, kind});
			chk("array address hi", e_op[23:16], addr[23:16]);
			chk("array address mid", e_op[15:8], addr[15:8]);
		end
	// Software reset pulses seen
	always @(negedge clk_in)
		if (srst === 1'b1)
			n_srst++;
	// Nonvolatile protection store
	always @(negedge clk_in)
		if (nv_wr === 1'b1)
			prot_nv <= nv_data;
	// Watchdog, about three and a half times the expected run length
	initial
	begin
		#600000;
		n_fail++;
		tally_and_finish();
	end
	initial
	begin
		{reset_n_in, lock_nv, vol_sel, tgt, sec_done, done, fail, hit} = 8'h00;
		wp_n = 1'b1;
		prot_nv = 3'h5;
		seed = 22;
		repeat (2) @(negedge clk_in);
		reset_n_in = 1'b1;
		repeat (6) @(negedge clk_in);
		rd(OPC_RD_STATUS_ONE, 24'h0, 8'h14);
		rd(OPC_RD_STATUS_TWO, 24'h0, 8'h00);
		cmd(OPC_REG_WRITE, 24'h600000, 2);
		rd(OPC_RD_STATUS_ONE, 24'h0, 8'h14);
		cmd(OPC_WRITE_ENABLE, 24'h0, 1);
		rd(OPC_RD_STATUS_ONE, 24'h0, 8'h16);
		cmd(OPC_WHOLE_ERASE, 24'h0, 1);
		rd(OPC_RD_STATUS_ONE, 24'h0, 8'h16);
		cmd(OPC_REG_WRITE, 24'h600000, 2);
		rd(OPC_RD_STATUS_ONE, 24'h0, 8'h00);
		lock_nv = 1'b1;
		wp_n = 1'b0;
		rd(OPC_RD_STATUS_ONE, 24'h0, 8'h80);
		cmd(OPC_WRITE_ENABLE, 24'h0, 1);
		cmd(OPC_REG_WRITE, 24'h1c0000, 2);
		rd(OPC_RD_STATUS_ONE, 24'h0, 8'h82);
		// Volatile protection mode, random level
		wp_n = 1'b1;
		vol_sel = 1'b1;
		r = $random(seed);
		cmd(OPC_REG_WRITE, {3'b111, r[2:0], 2'b11, 16'h0}, 2);
		rd(OPC_RD_STATUS_ONE, 24'h0, {3'b100, r[2:0], 2'b00});
		chk("protect level", {5'h0, r[2:0]}, {5'h0, prot});
		cmd(OPC_WRITE_ENABLE, 24'h0, 1);
		cmd(OPC_ANY_REG_WRITE, ADDR_STATUS_ONE, 5);
		rd(OPC_ANY_REG_READ, ADDR_STATUS_ONE, 8'h80);
		lock_nv = 1'b0;
		rd(OPC_ANY_REG_READ, 24'h800007, 8'h00);
		// Whole erase meeting a protected sector
		cmd(OPC_WRITE_ENABLE, 24'h0, 1);
		kind_q.push_back({KIND_WHOLE_ERASE, 24'h000000});
		cmd(OPC_WHOLE_ERASE, 24'h0, 1);
		cmd(OPC_WRITE_DISABLE, 24'h0, 1);
		rd(OPC_RD_STATUS_ONE, 24'h0, 8'h03);
		finish_op(1'b1, 1'b1);
		rd(OPC_RD_STATUS_ONE, 24'h0, 8'h00);
		// Erase of a protected sector
		tgt = 1'b1;
		cmd(OPC_WRITE_ENABLE, 24'h0, 1);
		cmd(OPC_SECTOR_ERASE, 24'h010000, 4);
		rd(OPC_RD_STATUS_ONE, 24'h0, 8'h23);
		tgt = 1'b0;
		cmd(OPC_CLEAR_STATUS_B, 24'h0, 1);
		rd(OPC_RD_STATUS_ONE, 24'h0, 8'h02);
		cmd(OPC_WRITE_DISABLE, 24'h0, 1);
		rd(OPC_RD_STATUS_ONE, 24'h0, 8'h00);
		// Program with suspend, then failure
		cmd(OPC_WRITE_ENABLE, 24'h0, 1);
		kind_q.push_back({KIND_PROGRAM, 24'h000100});
		cmd(OPC_PROGRAM, 24'h000100, 4);
		cmd(OPC_ERASE_SUSPEND, 24'h0, 1);
		rd(OPC_RD_STATUS_TWO, 24'h0, 8'h00);
		cmd(OPC_PROGRAM_SUSPEND, 24'h0, 1);
		rd(OPC_RD_STATUS_TWO, 24'h0, 8'h01);
		cmd(OPC_RESUME, 24'h0, 1);
		rd(OPC_RD_STATUS_TWO, 24'h0, 8'h00);
		finish_op(1'b1, 1'b0);
		rd(OPC_RD_STATUS_ONE, 24'h0, 8'h43);
		cmd(OPC_CLEAR_STATUS_A, 24'h0, 1);
		rd(OPC_RD_STATUS_ONE, 24'h0, 8'h02);
		cmd(OPC_WRITE_DISABLE, 24'h0, 1);
		// Sector erase with suspend
		cmd(OPC_WRITE_ENABLE, 24'h0, 1);
		kind_q.push_back({KIND_SECTOR_ERASE, 24'h020000});
		cmd(OPC_SECTOR_ERASE, 24'h020000, 4);
		cmd(OPC_ERASE_SUSPEND, 24'h0, 1);
		rd(OPC_RD_STATUS_TWO, 24'h0, 8'h02);
		cmd(OPC_RESUME, 24'h0, 1);
		rd(OPC_RD_STATUS_TWO, 24'h0, 8'h00);
		finish_op(1'b0, 1'b0);
		rd(OPC_RD_STATUS_ONE, 24'h0, 8'h00);
		// Erase result of a named sector
		sec_done = 1'b1;
		cmd(OPC_ERASE_STATUS, 24'h020000, 4);
		rd(OPC_RD_STATUS_TWO, 24'h0, 8'h04);
		sec_done = 1'b0;
		cmd(OPC_ERASE_STATUS, 24'h020000, 4);
		rd(OPC_ANY_REG_READ, ADDR_STATUS_TWO, 8'h00);
		// Reloads after software and hardware reset
		prot_nv = 3'h7;
		cmd(OPC_WRITE_ENABLE, 24'h0, 1);
		cmd(OPC_SOFT_RESET, 24'h0, 1);
		rd(OPC_RD_STATUS_ONE, 24'h0, 8'h1c);
		cmd(OPC_WRITE_ENABLE, 24'h0, 1);
		rd(OPC_RD_STATUS_ONE, 24'h0, 8'h1e);
		reset_n_in = 1'b0;
		repeat (2) @(negedge clk_in);
		reset_n_in = 1'b1;
		repeat (6) @(negedge clk_in);
		rd(OPC_RD_STATUS_ONE, 24'h0, 8'h1c);
		chk("soft reset pulses", 8'h01, n_srst[7:0]);
		chk("pending starts", 8'h00, 8'(kind_q.size()));
		@(negedge clk_in);
		tally_and_finish();
	end
endmodule // flash_status_registers_test
`default_nettype wire
